// ==== ncbp_pkg.sv ====
// package: register map, field layout and constants of the nvm clock and block protect logic
package ncbp_pkg;
    localparam logic [3:0] OFS_CLOCK_DIVIDER  = 4'h0;
    localparam logic [3:0] OFS_OPTION_SECURE  = 4'h1;
    localparam logic [3:0] OFS_CONFIG         = 4'h2;
    localparam logic [3:0] OFS_PROTECT        = 4'h3;
    localparam logic [3:0] OFS_STATUS         = 4'h4;
    localparam logic [3:0] OFS_COMMAND        = 4'h5;
    localparam logic [3:0] OFS_KEY_SELECT     = 4'h6;
    localparam logic [3:0] OFS_KEY_DATA       = 4'h7;
    localparam int         NUM_CTRL_REGS      = 7;
    localparam int         KEY_BYTES          = 8;
    localparam int         DIV_LOCK_BIT       = 7;
    localparam int         STAT_ACCERR_BIT    = 4;
    localparam int         STAT_VIOL_BIT      = 5;
    localparam int         PROT_OVR_BIT       = 0;
    localparam logic [7:0] DIVIDER_RESET      = 8'h00;
    localparam logic [7:0] CONFIG_RESET       = 8'h00;
    localparam logic [7:0] STATUS_RESET       = 8'h00;
    localparam logic [7:0] COMMAND_RESET      = 8'h00;
    localparam logic [4:0] PS_NONE            = 5'h1F;
    localparam logic [4:0] PS_ARR0_LAST       = 5'h17;
    localparam logic [4:0] PS_ARR1_4K_LAST    = 5'h10;
    localparam logic [16:0] ARR0_TOP_BOUND    = 17'h1_0000;
    localparam logic [16:0] ARR1_4K_TOP_BOUND = 17'h2_0000;
    localparam logic [16:0] ARR1_2K_TOP_BOUND = 17'h1_8800;
    localparam logic [16:0] STEP_8K           = 17'h0_2000;
    localparam logic [16:0] STEP_4K           = 17'h0_1000;
    localparam logic [16:0] STEP_2K           = 17'h0_0800;
    localparam logic [16:0] BOUND_ALL         = 17'h0_0000;
    localparam logic [16:0] BOUND_NONE        = 17'h1_FFFF;
    localparam logic [7:0] CMD_BYTE_PROGRAM   = 8'h20;
    localparam logic [7:0] CMD_BURST_PROGRAM  = 8'h25;
    localparam logic [7:0] CMD_SECTOR_ERASE   = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE     = 8'h41;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ncbp_bus_t;

    typedef struct packed {
        logic        valid;
        logic [16:0] addr;
        logic [7:0]  cmd;
    } ncbp_req_t;

    typedef enum logic [1:0] {
        NCBP_IDLE   = 2'b00,
        NCBP_CHECK  = 2'b01,
        NCBP_ACCEPT = 2'b11,
        NCBP_REJECT = 2'b10
    } ncbp_state_t;
endpackage

// ==== ncbp_range.sv ====
// protect-size decoder: lowest protected address of the 128 KB flash span
`timescale 1ns/1ps
`default_nettype none
module ncbp_range (
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    input  wire logic [4:0]  i_protect_size_field,
    input  wire logic        i_protect_override_bit,
    output logic      [16:0] o_bound,
    output logic             o_none
);
    import ncbp_pkg::*;

    typedef struct packed {
        logic [16:0] bound;
        logic        none;
    } ncbp_range_st_t;

    ncbp_range_st_t st_ff;
    ncbp_range_st_t nxt_st;
    logic [16:0]    ps_ext;

    always_comb begin
        ps_ext = {12'h000, i_protect_size_field};
        nxt_st = st_ff;
        if (!i_protect_override_bit) begin
            nxt_st.bound = BOUND_ALL;
            nxt_st.none  = 1'b0;
        end else if (i_protect_size_field == PS_NONE) begin
            nxt_st.bound = BOUND_NONE;
            nxt_st.none  = 1'b1;
        end else if (i_protect_size_field >= PS_ARR0_LAST) begin
            nxt_st.bound = 17'(ARR0_TOP_BOUND - STEP_8K * (17'h1F - ps_ext));
            nxt_st.none  = 1'b0;
        end else if (i_protect_size_field >= PS_ARR1_4K_LAST) begin
            nxt_st.bound = 17'(ARR1_4K_TOP_BOUND - STEP_4K * (17'h17 - ps_ext));
            nxt_st.none  = 1'b0;
        end else begin
            nxt_st.bound = 17'(ARR1_2K_TOP_BOUND - STEP_2K * (17'h10 - ps_ext));
            nxt_st.none  = 1'b0;
        end
    end

    // reset to fully protected so nothing slips through before the first decode
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= '{bound: 17'h0_0000, none: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_bound = st_ff.bound;
    assign o_none  = st_ff.none;

    AST_OVR_ALL: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        !i_protect_override_bit |=> (o_bound == 17'h0_0000) && !o_none)
        else $error("override clear did not protect everything");
    AST_NONE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_protect_override_bit && i_protect_size_field == 5'h1F) |=> o_none)
        else $error("0x1F with override did not unprotect");
    AST_ARR0_1E: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_protect_override_bit && i_protect_size_field == 5'h1E) |=> o_bound == 17'h0_E000)
        else $error("size 0x1E bound wrong");
    AST_ARR1_10: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_protect_override_bit && i_protect_size_field == 5'h10) |=> o_bound == 17'h1_9000)
        else $error("size 0x10 bound wrong");
    AST_ARR1_00: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_protect_override_bit && i_protect_size_field == 5'h00) |=> o_bound == 17'h1_0800)
        else $error("size 0x00 bound wrong");
endmodule
`default_nettype wire

// ==== ncbp_top.sv ====
// nvm clock divider, option load, key store and block protect control
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ncbp_top (
    input  wire logic              i_clock,
    input  wire logic              i_rst_b,
    input  wire ncbp_pkg::ncbp_bus_t i_bus,
    output logic            [7:0]  o_rdata,
    input  wire logic              i_nv_load,
    input  wire logic       [7:0]  i_nv_protect,
    input  wire logic       [7:0]  i_nv_secure,
    input  wire logic       [7:0]  i_nv_option,
    input  wire logic       [63:0] i_nv_key,
    input  wire ncbp_pkg::ncbp_req_t i_req,
    output logic                   o_cmd_start,
    output logic            [16:0] o_cmd_addr,
    output logic            [7:0]  o_cmd_code,
    output logic                   o_access_error_flag,
    output logic                   o_violation_flag,
    output logic            [6:0]  o_nvm_clock_divider,
    output logic                   o_divider_locked,
    output logic            [63:0] o_key
);
    import ncbp_pkg::*;

    typedef struct packed {
        logic [7:0]        rdata;
        logic [6:0]        divider;
        logic              locked;
        logic [7:0]        option_secure;
        logic [7:0]        config_reg;
        logic [7:0]        protect;
        logic [7:0]        option_copy;
        logic              accerr;
        logic              viol;
        logic [7:0]        command;
        logic [2:0]        key_sel;
        logic [63:0]       key;
        logic              loaded;
        ncbp_state_t       state;
        logic [16:0]       req_addr;
        logic [7:0]        req_cmd;
        logic              start;
    } ncbp_st_t;

    ncbp_st_t    st_ff;
    ncbp_st_t    nxt_st;
    logic [16:0] bound;
    logic        no_prot;
    logic        wr_div;
    logic        wr_stat;

    function automatic logic is_wr(input ncbp_bus_t b, input logic [3:0] ofs);
        return b.wr && (b.addr == ofs);
    endfunction

    function automatic logic is_program_erase(input logic [7:0] c);
        return (c == CMD_BYTE_PROGRAM) || (c == CMD_BURST_PROGRAM) ||
               (c == CMD_SECTOR_ERASE) || (c == CMD_MASS_ERASE);
    endfunction

    ncbp_range u_range (
        .i_clock                (i_clock),
        .i_rst_b                (i_rst_b),
        .i_protect_size_field   (st_ff.protect[5:1]),
        .i_protect_override_bit (st_ff.protect[PROT_OVR_BIT]),
        .o_bound                (bound),
        .o_none                 (no_prot)
    );

    assign wr_div  = is_wr(i_bus, OFS_CLOCK_DIVIDER);
    assign wr_stat = is_wr(i_bus, OFS_STATUS);

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.start = 1'b0;
        // option image copied once after reset release
        if (i_nv_load && !st_ff.loaded) begin
            nxt_st.protect       = i_nv_protect;
            nxt_st.option_secure = i_nv_secure;
            nxt_st.option_copy   = i_nv_option;
            nxt_st.key           = i_nv_key;
            nxt_st.loaded        = 1'b1;
        end
        // a second write is silently dropped, bit seven ignores data
        if (wr_div && !st_ff.locked) begin
            nxt_st.divider = i_bus.wdata[6:0];
            nxt_st.locked  = 1'b1;
        end
        if (is_wr(i_bus, OFS_CONFIG)) begin
            nxt_st.config_reg = i_bus.wdata;
        end
        if (is_wr(i_bus, OFS_PROTECT)) begin
            nxt_st.protect = i_bus.wdata;
        end
        if (is_wr(i_bus, OFS_COMMAND)) begin
            nxt_st.command = i_bus.wdata;
        end
        if (is_wr(i_bus, OFS_KEY_SELECT)) begin
            nxt_st.key_sel = i_bus.wdata[2:0];
        end
        if (wr_stat && i_bus.wdata[STAT_ACCERR_BIT]) begin
            nxt_st.accerr = 1'b0;
        end
        if (wr_stat && i_bus.wdata[STAT_VIOL_BIT]) begin
            nxt_st.viol = 1'b0;
        end
        case (st_ff.state)
            NCBP_IDLE: begin
                if (i_req.valid) begin
                    nxt_st.req_addr = i_req.addr;
                    nxt_st.req_cmd  = i_req.cmd;
                    nxt_st.state    = NCBP_CHECK;
                end
            end
            NCBP_CHECK: begin
                // flags set here win over a clear in the same cycle
                if (st_ff.accerr) begin
                    nxt_st.state = NCBP_REJECT;
                end else if (!st_ff.locked) begin
                    nxt_st.accerr = 1'b1;
                    nxt_st.state  = NCBP_REJECT;
                end else if (is_program_erase(st_ff.req_cmd) && !no_prot &&
                             (st_ff.req_addr >= bound)) begin
                    nxt_st.viol  = 1'b1;
                    nxt_st.state = NCBP_REJECT;
                end else begin
                    nxt_st.state = NCBP_ACCEPT;
                end
            end
            NCBP_ACCEPT: begin
                nxt_st.start = 1'b1;
                nxt_st.state = NCBP_IDLE;
            end
            NCBP_REJECT: begin
                nxt_st.state = NCBP_IDLE;
            end
            default: begin
                nxt_st.state = NCBP_IDLE;
            end
        endcase
        nxt_st.rdata = 8'h00;
        if (i_bus.rd) begin
            case (i_bus.addr)
                OFS_CLOCK_DIVIDER: nxt_st.rdata = {st_ff.locked, st_ff.divider};
                OFS_OPTION_SECURE: nxt_st.rdata = st_ff.option_secure;
                OFS_CONFIG:        nxt_st.rdata = st_ff.config_reg;
                OFS_PROTECT:       nxt_st.rdata = st_ff.protect;
                OFS_STATUS:        nxt_st.rdata = {2'b00, st_ff.viol, st_ff.accerr,
                                                   3'b000, st_ff.state == NCBP_IDLE};
                OFS_COMMAND:       nxt_st.rdata = st_ff.command;
                OFS_KEY_SELECT:    nxt_st.rdata = {5'h00, st_ff.key_sel};
                OFS_KEY_DATA:      nxt_st.rdata = st_ff.key[st_ff.key_sel*8 +: 8];
                default:           nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= '{rdata: 8'h00, divider: 7'h00, locked: 1'b0, option_secure: 8'h00,
                       config_reg: 8'h00, protect: 8'h00, option_copy: 8'h00,
                       accerr: 1'b0, viol: 1'b0, command: 8'h00, key_sel: 3'h0,
                       key: 64'h0, loaded: 1'b0, state: NCBP_IDLE,
                       req_addr: 17'h0_0000, req_cmd: 8'h00, start: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_rdata             = st_ff.rdata;
    assign o_cmd_start         = st_ff.start;
    assign o_cmd_addr          = st_ff.req_addr;
    assign o_cmd_code          = st_ff.req_cmd;
    assign o_access_error_flag = st_ff.accerr;
    assign o_violation_flag    = st_ff.viol;
    assign o_nvm_clock_divider = st_ff.divider;
    assign o_divider_locked    = st_ff.locked;
    assign o_key               = st_ff.key;

    sequence s_div_write;
        wr_div && !o_divider_locked;
    endsequence

    AST_DIV_ONCE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (wr_div && o_divider_locked) |=> $stable(o_nvm_clock_divider))
        else $error("divider changed on a later write");
    AST_DIV_LOCK: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        s_div_write |=> o_divider_locked && o_nvm_clock_divider == $past(i_bus.wdata[6:0]))
        else $error("first divider write not taken or not locked");
    AST_DIV_READ: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_bus.rd && i_bus.addr == 4'h0) |=> o_rdata == {o_divider_locked, o_nvm_clock_divider})
        else $error("divider read wrong");
    AST_NO_DIV: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_req.valid && st_ff.state == NCBP_IDLE && !o_divider_locked && !wr_div)
        |=> ##1 o_access_error_flag ##1 !o_cmd_start)
        else $error("flash write before divider not refused");
    AST_ERR_BLOCK: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (st_ff.state == NCBP_CHECK && o_access_error_flag) |=> ##1 !o_cmd_start)
        else $error("command processed while access error set");
    AST_ERR_CLR: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (o_access_error_flag && !(wr_stat && i_bus.wdata[4])) |=> o_access_error_flag)
        else $error("access error cleared without a one write");
    AST_PROT: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (st_ff.state == NCBP_CHECK && !o_access_error_flag && o_divider_locked &&
         is_program_erase(st_ff.req_cmd) && !no_prot && st_ff.req_addr >= bound)
        |=> o_violation_flag ##1 !o_cmd_start)
        else $error("protected command not rejected");
    AST_LOAD: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_nv_load && !st_ff.loaded && !i_bus.wr) |=> st_ff.protect == $past(i_nv_protect))
        else $error("option not copied at reset");
endmodule
`default_nettype wire

// ==== ncbp_top_test.sv ====
// self-checking testbench for the nvm clock divider and block protect control
`timescale 1ns/1ps
`default_nettype none
module ncbp_top_test;
    import ncbp_pkg::*;
    logic               i_clock;
    logic               i_rst_b;
    ncbp_bus_t          i_bus;
    logic        [7:0]  o_rdata;
    logic               i_nv_load;
    logic        [7:0]  i_nv_protect;
    logic        [7:0]  i_nv_secure;
    logic        [7:0]  i_nv_option;
    logic        [63:0] i_nv_key;
    ncbp_req_t          i_req;
    logic               o_cmd_start;
    logic        [16:0] o_cmd_addr;
    logic        [7:0]  o_cmd_code;
    logic               o_access_error_flag;
    logic               o_violation_flag;
    logic        [6:0]  o_nvm_clock_divider;
    logic               o_divider_locked;
    logic        [63:0] o_key;
    int                 fails;
    int                 cmp_count;
    logic        [7:0]  rd;
    logic               st;

    ncbp_top ncbp_top_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_bus(i_bus),
        .o_rdata(o_rdata), .i_nv_load(i_nv_load), .i_nv_protect(i_nv_protect),
        .i_nv_secure(i_nv_secure), .i_nv_option(i_nv_option), .i_nv_key(i_nv_key),
        .i_req(i_req), .o_cmd_start(o_cmd_start), .o_cmd_addr(o_cmd_addr),
        .o_cmd_code(o_cmd_code), .o_access_error_flag(o_access_error_flag),
        .o_violation_flag(o_violation_flag), .o_nvm_clock_divider(o_nvm_clock_divider),
        .o_divider_locked(o_divider_locked), .o_key(o_key));

    always #50 i_clock = ~i_clock;

    task automatic check(input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clock);
        i_bus <= '0;
    endtask

    // read data stand only in the cycle after the strobe, so sample there
    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clock);
        i_bus <= '0;
        #1;
        d = o_rdata;
    endtask

    // requests are spaced well beyond the three-cycle engine turnaround
    task automatic send_req(input logic [16:0] a, input logic [7:0] c, output logic s);
        s = 1'b0;
        @(posedge i_clock);
        i_req <= '{valid: 1'b1, addr: a, cmd: c};
        @(posedge i_clock);
        i_req.valid <= 1'b0;
        repeat (6) begin
            @(posedge i_clock);
            #1;
            if (o_cmd_start === 1'b1) s = 1'b1;
        end
    endtask

    task automatic do_reset();
        @(posedge i_clock);
        i_rst_b <= 1'b0;
        repeat (4) @(posedge i_clock);
        i_rst_b <= 1'b1;
    endtask

    function automatic logic [16:0] bound_of(input logic [4:0] s);
        if (s >= 5'h17) return 17'h1_0000 - 17'(5'h1F - s) * 17'h0_2000;
        if (s >= 5'h10) return 17'h2_0000 - 17'(5'h17 - s) * 17'h0_1000;
        return 17'h1_8800 - 17'(5'h10 - s) * 17'h0_0800;
    endfunction

    task automatic t_reset_values();
        bus_rd(OFS_CLOCK_DIVIDER, rd); check(DIVIDER_RESET, rd);
        bus_rd(OFS_PROTECT, rd); check(8'h00, rd);
        bus_rd(4'h9, rd); check(8'h00, rd);
        check(1'b0, o_divider_locked);
        $display("test reset_values done");
    endtask

    task automatic t_early_cmd();
        send_req(17'h1_FFFF, CMD_BYTE_PROGRAM, st); check(1'b0, st);
        check(1'b1, o_access_error_flag);
        bus_wr(OFS_STATUS, 8'h00);
        send_req(17'h1_FFFF, CMD_MASS_ERASE, st); check(1'b0, st);
        check(1'b1, o_access_error_flag);
        bus_wr(OFS_STATUS, 8'h10);
        #1;
        check(1'b0, o_access_error_flag);
        $display("test early_cmd done");
    endtask

    task automatic t_divider_once();
        bus_wr(OFS_CLOCK_DIVIDER, 8'h05);
        bus_rd(OFS_CLOCK_DIVIDER, rd); check(8'h85, rd);
        check(7'h05, o_nvm_clock_divider);
        check(1'b1, o_divider_locked);
        bus_wr(OFS_CLOCK_DIVIDER, 8'h2A);
        bus_rd(OFS_CLOCK_DIVIDER, rd); check(8'h85, rd);
        $display("test divider_once done");
    endtask

    task automatic t_protect_table();
        logic [4:0]  sizes [7];
        logic [7:0]  codes [4];
        logic [16:0] b;
        sizes = '{5'h1E, 5'h17, 5'h16, 5'h10, 5'h0F, 5'h05, 5'h00};
        codes = '{CMD_BYTE_PROGRAM, CMD_BURST_PROGRAM, CMD_SECTOR_ERASE, CMD_MASS_ERASE};
        foreach (sizes[i]) begin
            bus_wr(OFS_PROTECT, {2'b00, sizes[i], 1'b1});
            b = bound_of(sizes[i]);
            if (b != 17'h0_0000) begin
                send_req(b - 17'h1, codes[i % 4], st); check(1'b1, st);
                check(b - 17'h1, o_cmd_addr);
                check(codes[i % 4], o_cmd_code);
            end
            send_req(b, codes[(i + 1) % 4], st); check(1'b0, st);
            check(1'b1, o_violation_flag);
            bus_wr(OFS_STATUS, 8'h20);
            #1;
            check(1'b0, o_violation_flag);
        end
        bus_wr(OFS_PROTECT, 8'h3F);
        send_req(17'h1_FFFF, CMD_SECTOR_ERASE, st); check(1'b1, st);
        bus_wr(OFS_PROTECT, 8'h3E);
        send_req(17'h0_0000, CMD_BYTE_PROGRAM, st); check(1'b0, st);
        check(1'b1, o_violation_flag);
        $display("test protect_table done");
    endtask

    task automatic t_option_load();
        i_nv_protect <= 8'h2D;
        i_nv_secure  <= 8'h5A;
        i_nv_key     <= 64'h0123_4567_89AB_CDEF;
        do_reset();
        @(posedge i_clock);
        i_nv_load <= 1'b1;
        repeat (3) @(posedge i_clock);
        bus_rd(OFS_PROTECT, rd); check(8'h2D, rd);
        bus_rd(OFS_OPTION_SECURE, rd); check(8'h5A, rd);
        check(64'h0123_4567_89AB_CDEF, o_key);
        bus_wr(OFS_KEY_SELECT, 8'h03);
        bus_rd(OFS_KEY_DATA, rd); check(8'h89, rd);
        bus_rd(OFS_CLOCK_DIVIDER, rd); check(8'h00, rd);
        bus_wr(OFS_CLOCK_DIVIDER, 8'h13);
        bus_rd(OFS_CLOCK_DIVIDER, rd); check(8'h93, rd);
        send_req(17'h1_EFFF, CMD_BURST_PROGRAM, st); check(1'b1, st);
        send_req(17'h1_F000, CMD_BURST_PROGRAM, st); check(1'b0, st);
        $display("test option_load done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        i_clock = 1'b0;
        i_rst_b = 1'b0;
        i_bus = '0;
        i_req = '0;
        i_nv_load = 1'b0;
        i_nv_protect = 8'h00;
        i_nv_secure = 8'h00;
        i_nv_option = 8'h00;
        i_nv_key = 64'h0;
        fails = 0;
        cmp_count = 0;
        repeat (4) @(posedge i_clock);
        i_rst_b <= 1'b1;
        t_reset_values();
        t_early_cmd();
        t_divider_once();
        t_protect_table();
        t_option_load();
        report_and_stop();
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        #(100 * 20000);
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
